// ---- common/scdb_pkg.sv ----
// Purpose: shared constants, types and helpers of the command-block / geometry register bank
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   offsets, masks, message codes and limits live here; period and strobe values sit in scdb_sync_decode
package scdb_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CYL_TOTAL = 8'h00;
  localparam logic [7:0] OFS_LADDR     = 8'h04;
  localparam logic [7:0] OFS_SECTOR    = 8'h08;
  localparam logic [7:0] OFS_HEAD      = 8'h0C;
  localparam logic [7:0] OFS_CYL_NUM   = 8'h10;
  localparam logic [7:0] OFS_LUN       = 8'h14;
  localparam logic [7:0] OFS_PHASE     = 8'h18;
  localparam logic [7:0] OFS_SYNC      = 8'h1C;
  localparam logic [7:0] OFS_LAST      = 8'h1C;

  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // field layouts
  localparam logic [7:0] LUN_WR_MASK   = 8'hC7; // lun_valid, disconnect_permitted, logical_unit_field
  localparam int         LUN_VALID_BIT = 7;
  localparam int         LUN_DOK_BIT   = 6;
  localparam logic [7:0] PHASE_MASK    = 8'h7F; // phase_progress_field
  localparam logic [7:0] SYNC_MASK     = 8'h7F; // period_field 6:4, sync_offset_field 3:0
  localparam int         CMS_LINK_BIT  = 8;     // completion_msg_select bit 0 in cylinder number
  localparam int         CMS_FLAG_BIT  = 9;     // completion_msg_select bit 1

  // completion messages
  localparam logic [7:0] MSG_COMPLETE      = 8'h00;
  localparam logic [7:0] MSG_LINKED        = 8'h0A;
  localparam logic [7:0] MSG_LINKED_FLAG   = 8'h0B;

  // synchronous offset limits
  localparam logic [3:0] OFFSET_MAX = 4'hC;

  // divider
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef enum logic [1:0] {
    SCDB_LEN6  = 2'b00,
    SCDB_LEN10 = 2'b01,
    SCDB_LEN12 = 2'b10
  } scdb_len_t;

  // update request from the command engine / bus sequencer
  typedef struct packed {
    logic       cdb_we;      // store a received command block byte
    logic [3:0] cdb_idx;     // byte number, 3..12
    logic [7:0] cdb_data;
    logic       status_we;   // target status byte received
    logic [7:0] status;
    logic       ident_we;    // command reception finished
    logic       ident_valid;
    logic       ident_dok;
    logic [2:0] ident_lun;
    logic       unexp_we;    // unexpected reselection in advanced mode
    logic [2:0] unexp_lun;
    logic       phase_we;
    logic [6:0] phase;
  } scdb_upd_t;

  // view handed back to the engine
  typedef struct packed {
    logic [7:0] cdb_rd_data;
    logic [2:0] ident_lun;
    logic [7:0] status_byte;
    logic [7:0] complete_msg;
    logic [6:0] phase;
  } scdb_view_t;

  // transfer settings
  typedef struct packed {
    logic       sync_en;
    logic       offset_undef;
    logic [3:0] offset;
    logic [3:0] period;
    logic [2:0] strobe;
  } scdb_xfer_t;

  // apply APB byte strobes
  function automatic logic [31:0] merge_strb(logic [31:0] old, logic [31:0] wd, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        r[k*8 +: 8] = wd[k*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  // conditionally place a byte in a lane
  function automatic logic [31:0] put_if(logic [31:0] v, logic en, logic [1:0] lane, logic [7:0] d);
    logic [31:0] r;
    r = v;
    if (en) begin
      r[lane*8 +: 8] = d;
    end
    return r;
  endfunction : put_if

  // command block byte present for this block length
  function automatic logic cdb_allowed(logic [3:0] idx, scdb_len_t len);
    logic r;
    r = 1'b0;
    if (idx >= 4'h3 && idx <= 4'h6) begin
      r = 1'b1;
    end else if (idx >= 4'h7 && idx <= 4'hA) begin
      r = (len != SCDB_LEN6);
    end else if (idx == 4'hB || idx == 4'hC) begin
      r = (len == SCDB_LEN12);
    end
    return r;
  endfunction : cdb_allowed

endpackage : scdb_pkg

// ---- hw/scdb_sync_decode.sv ----
// Purpose: decode synchronous offset and period setting into transfer controls
// Assumes: i_data_phase is on i_clk
// Notes:   outputs registered; undefined offsets fall back to asynchronous
`timescale 1ns/1ps
`default_nettype none
module scdb_sync_decode (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic [6:0]        i_sync,
  input  wire logic              i_data_phase,
  output var scdb_pkg::scdb_xfer_t o_xfer
);

  logic [3:0]          offset;
  logic [2:0]          tp;
  logic                undef;
  logic [3:0]          period;
  logic [2:0]          strobe;
  scdb_pkg::scdb_xfer_t xfer_ff;
  scdb_pkg::scdb_xfer_t nxt_xfer;

  // field split and offset legality
  assign offset = i_sync[3:0];
  assign tp     = i_sync[6:4];
  assign undef  = (offset > scdb_pkg::OFFSET_MAX);

  // period and strobe width in divided cycles
  assign period = (tp[2:1] == 2'b00) ? 4'h8 : {1'b0, tp};
  assign strobe = (tp[2:1] == 2'b00) ? 3'h4 :
                  (tp == 3'h2 || tp == 3'h3) ? 3'h1 :
                  (tp == 3'h4) ? 3'h2 :
                  (tp == 3'h5) ? 3'h3 : 3'h4;

  // synchronous only in data phases with a defined nonzero offset
  assign nxt_xfer.sync_en      = i_data_phase && (offset != 4'h0) && !undef;
  assign nxt_xfer.offset_undef = undef;
  assign nxt_xfer.offset       = undef ? 4'h0 : offset;
  assign nxt_xfer.period       = period;
  assign nxt_xfer.strobe       = strobe;

  // output register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      xfer_ff <= '0;
    end else begin
      xfer_ff <= nxt_xfer;
    end
  end

  assign o_xfer = xfer_ff;

endmodule : scdb_sync_decode
`default_nettype wire

// ---- hw/scdb_xlate.sv ----
// Purpose: logical address to cylinder / head / sector translation
// Assumes: operands stable from start to done
// Notes:   two 32-step shift-subtract divisions, 65 cycles start to done
`timescale 1ns/1ps
`default_nettype none
module scdb_xlate (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_start,
  input  wire logic [31:0] i_laddr,
  input  wire logic [7:0]  i_spt,
  input  wire logic [7:0]  i_heads,
  input  wire logic [7:0]  i_spare,
  input  wire logic [15:0] i_cyl_init,
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_sector,
  output logic [7:0]       o_head,
  output logic [15:0]      o_cyl
);

  typedef enum logic [1:0] {
    SCDB_X_IDLE = 2'b00,
    SCDB_X_DIV1 = 2'b01,
    SCDB_X_DIV2 = 2'b10
  } scdb_xst_t;

  scdb_xst_t   st_ff;
  logic [31:0] quo_ff;
  logic [15:0] rem_ff;
  logic [15:0] div_ff;
  logic [5:0]  cnt_ff;
  logic        comp_ff;
  logic        done_ff;
  logic [7:0]  sector_ff;
  logic [7:0]  head_ff;
  logic [15:0] cyl_ff;
  logic [31:0] q1_ff;
  logic        busy_ff;
  logic [16:0] rem_sh;
  logic        fits;
  logic [31:0] nxt_quo;
  logic [15:0] nxt_rem;
  logic        last;

  // one restoring division step
  assign rem_sh  = {rem_ff, quo_ff[31]};
  assign fits    = (rem_sh >= {1'b0, div_ff});
  assign nxt_rem = fits ? 16'(rem_sh - {1'b0, div_ff}) : rem_sh[15:0];
  assign nxt_quo = {quo_ff[30:0], fits};
  assign last    = (cnt_ff == scdb_pkg::DIV_STEPS - 6'h1);

  // sequencer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff     <= SCDB_X_IDLE;
      quo_ff    <= '0;
      rem_ff    <= '0;
      div_ff    <= '0;
      cnt_ff    <= '0;
      comp_ff   <= 1'b0;
      done_ff   <= 1'b0;
      q1_ff     <= '0;
      busy_ff   <= 1'b0;
      sector_ff <= '0;
      head_ff   <= '0;
      cyl_ff    <= '0;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        SCDB_X_IDLE: begin
          if (i_start) begin
            comp_ff <= (i_spare != 8'h00);
            quo_ff  <= i_laddr;
            rem_ff  <= '0;
            div_ff  <= (i_spare != 8'h00) ? i_cyl_init : {8'h00, i_spt};
            cnt_ff  <= '0;
            st_ff   <= SCDB_X_DIV1;
            busy_ff <= 1'b1;
          end
        end
        SCDB_X_DIV1: begin
          quo_ff <= nxt_quo;
          rem_ff <= nxt_rem;
          cnt_ff <= cnt_ff + 6'h1;
          if (last) begin
            q1_ff  <= comp_ff ? nxt_quo : 32'(nxt_rem);
            quo_ff <= comp_ff ? {16'h0000, nxt_rem} : nxt_quo;
            rem_ff <= '0;
            div_ff <= {8'h00, comp_ff ? i_spt : i_heads};
            cnt_ff <= '0;
            st_ff  <= SCDB_X_DIV2;
          end
        end
        SCDB_X_DIV2: begin
          quo_ff <= nxt_quo;
          rem_ff <= nxt_rem;
          cnt_ff <= cnt_ff + 6'h1;
          if (last) begin
            sector_ff <= comp_ff ? nxt_rem[7:0] : q1_ff[7:0];
            head_ff   <= comp_ff ? nxt_quo[7:0] : nxt_rem[7:0];
            cyl_ff    <= comp_ff ? q1_ff[15:0] : nxt_quo[15:0];
            done_ff   <= 1'b1;
            busy_ff   <= 1'b0;
            st_ff     <= SCDB_X_IDLE;
          end
        end
        default: begin
          st_ff <= SCDB_X_IDLE;
        end
      endcase
    end
  end

  assign o_busy   = busy_ff;
  assign o_done   = done_ff;
  assign o_sector = sector_ff;
  assign o_head   = head_ff;
  assign o_cyl    = cyl_ff;

endmodule : scdb_xlate
`default_nettype wire

// ---- hw/scdb_regs.sv ----
// Purpose: APB register bank for command block bytes, translation, unit, phase and transfer settings
// Assumes: engine update requests arrive on i_clk; APB master per the AMBA protocol
// Notes:   hardware updates win over a software write in the same cycle
// Functional notes
// - cylinder total register holds a 16-bit cylinder count for translation.
// - received command block bytes three and four land in cylinder total.
// - bytes five and six always, seven and eight only for long blocks.
// - translation leaves the computed sector in the sector register.
// - sector register carries byte nine only for ten or twelve byte blocks.
// - head register gets the result; zero beforehand disables spare compensation.
// - head register carries byte ten only for ten or twelve byte blocks.
// - cylinder number gets the result; preloaded net sectors per cylinder when compensating.
// - twelve byte reception puts bytes eleven and twelve in cylinder number.
// - status byte sent is the low byte of cylinder number.
// - high byte bit0 picks linked message, bit1 picks 0A or 0B, else 00.
// - unit register builds identify and stores received target status.
// - after reception lun valid only on valid identify, then disconnect permitted.
// - reselect identify uses bits 2 to 0, ignoring valid and permitted flags.
// - unexpected reselection stores its unit and clears both flags.
// - seven-bit phase field tracks progress; bit 7 reads zero.
// - host writes next phase and reissues; engine resumes from it.
// - asynchronous outside data phases or when offset is zero.
// - offsets 1 to 12 select synchronous transfer; higher codes undefined.
// - period field sets minimum transfer period and strobe width.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scdb_regs (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  input  wire logic [3:0]           i_pstrb,
  output logic [31:0]               o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  input  wire scdb_pkg::scdb_upd_t  i_upd,
  input  wire scdb_pkg::scdb_len_t  i_cdb_len,
  input  wire logic [3:0]           i_cdb_rd_idx,
  input  wire logic                 i_xlate_start,
  input  wire logic [7:0]           i_total_sectors,
  input  wire logic [7:0]           i_total_heads,
  input  wire logic                 i_data_phase,
  output scdb_pkg::scdb_view_t      o_view,
  output scdb_pkg::scdb_xfer_t      o_xfer,
  output logic                      o_xlate_busy,
  output logic                      o_xlate_done
);

  // storage
  logic [15:0]          cyl_total_ff;
  logic [31:0]          laddr_ff;
  logic [7:0]           sector_ff;
  logic [7:0]           head_ff;
  logic [15:0]          cyl_num_ff;
  logic [7:0]           lun_ff;
  logic [6:0]           phase_ff;
  logic [6:0]           sync_ff;
  logic [31:0]          prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  scdb_pkg::scdb_view_t view_ff;

  // next values
  logic [15:0]          nxt_cyl_total;
  logic [31:0]          nxt_laddr;
  logic [7:0]           nxt_sector;
  logic [7:0]           nxt_head;
  logic [15:0]          nxt_cyl_num;
  logic [7:0]           nxt_lun;
  logic [6:0]           nxt_phase;
  logic [6:0]           nxt_sync;
  scdb_pkg::scdb_view_t nxt_view;

  // bus decode
  logic                 setup;
  logic                 mapped;
  logic                 wr_en;
  logic [31:0]          rd_mux;
  logic [31:0]          sw_cyl_total;
  logic [31:0]          sw_laddr;
  logic [31:0]          sw_sector;
  logic [31:0]          sw_head;
  logic [31:0]          sw_cyl_num;
  logic [31:0]          sw_lun;
  logic [31:0]          sw_phase;
  logic [31:0]          sw_sync;
  logic [12:3]          cdb_w;
  logic [31:0]          hw_cyl_total;
  logic [31:0]          hw_laddr;
  logic [31:0]          hw_cyl_num;
  logic [7:0]           cdb_rd;
  logic [7:0]           msg;

  // translation unit
  logic                 x_done;
  logic                 x_busy;
  logic [7:0]           x_sector;
  logic [7:0]           x_head;
  logic [15:0]          x_cyl;

  // APB phases: answer prepared in setup, taken in the first access cycle
  assign setup  = i_psel && !i_penable;
  assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= scdb_pkg::OFS_LAST);
  assign wr_en  = i_psel && i_penable && pready_ff && i_pwrite && !pslverr_ff;

  // software write images, masked to implemented bits
  assign sw_cyl_total = (wr_en && i_paddr == scdb_pkg::OFS_CYL_TOTAL) ?
                        (scdb_pkg::merge_strb({16'h0000, cyl_total_ff}, i_pwdata, i_pstrb) & 32'h0000_FFFF) :
                        {16'h0000, cyl_total_ff};
  assign sw_laddr     = (wr_en && i_paddr == scdb_pkg::OFS_LADDR) ?
                        scdb_pkg::merge_strb(laddr_ff, i_pwdata, i_pstrb) : laddr_ff;
  assign sw_sector    = (wr_en && i_paddr == scdb_pkg::OFS_SECTOR) ?
                        scdb_pkg::merge_strb({24'h000000, sector_ff}, i_pwdata, i_pstrb) :
                        {24'h000000, sector_ff};
  assign sw_head      = (wr_en && i_paddr == scdb_pkg::OFS_HEAD) ?
                        scdb_pkg::merge_strb({24'h000000, head_ff}, i_pwdata, i_pstrb) :
                        {24'h000000, head_ff};
  assign sw_cyl_num   = (wr_en && i_paddr == scdb_pkg::OFS_CYL_NUM) ?
                        scdb_pkg::merge_strb({16'h0000, cyl_num_ff}, i_pwdata, i_pstrb) :
                        {16'h0000, cyl_num_ff};
  assign sw_lun       = (wr_en && i_paddr == scdb_pkg::OFS_LUN) ?
                        (scdb_pkg::merge_strb({24'h000000, lun_ff}, i_pwdata, i_pstrb)
                         & {24'h000000, scdb_pkg::LUN_WR_MASK}) :
                        {24'h000000, lun_ff};
  assign sw_phase     = (wr_en && i_paddr == scdb_pkg::OFS_PHASE) ?
                        (scdb_pkg::merge_strb({25'h0000000, phase_ff}, i_pwdata, i_pstrb)
                         & {24'h000000, scdb_pkg::PHASE_MASK}) :
                        {25'h0000000, phase_ff};
  assign sw_sync      = (wr_en && i_paddr == scdb_pkg::OFS_SYNC) ?
                        (scdb_pkg::merge_strb({25'h0000000, sync_ff}, i_pwdata, i_pstrb)
                         & {24'h000000, scdb_pkg::SYNC_MASK}) :
                        {25'h0000000, sync_ff};

  // received command block byte strobes, gated by block length
  genvar gi;
  generate
    for (gi = 3; gi <= 12; gi++) begin : g_cdb
      assign cdb_w[gi] = i_upd.cdb_we && (i_upd.cdb_idx == 4'(gi))
                         && scdb_pkg::cdb_allowed(4'(gi), i_cdb_len);
    end
  endgenerate

  // byte placement: lowest numbered byte in the lowest lane
  assign hw_cyl_total = scdb_pkg::put_if(scdb_pkg::put_if(sw_cyl_total, cdb_w[3], 2'd0, i_upd.cdb_data),
                                         cdb_w[4], 2'd1, i_upd.cdb_data);
  assign hw_laddr     = scdb_pkg::put_if(scdb_pkg::put_if(scdb_pkg::put_if(scdb_pkg::put_if(sw_laddr,
                          cdb_w[5], 2'd0, i_upd.cdb_data), cdb_w[6], 2'd1, i_upd.cdb_data),
                          cdb_w[7], 2'd2, i_upd.cdb_data), cdb_w[8], 2'd3, i_upd.cdb_data);
  assign hw_cyl_num   = scdb_pkg::put_if(scdb_pkg::put_if(sw_cyl_num, cdb_w[11], 2'd0, i_upd.cdb_data),
                                         cdb_w[12], 2'd1, i_upd.cdb_data);

  // next values, hardware results over software writes
  assign nxt_cyl_total = hw_cyl_total[15:0];
  assign nxt_laddr     = hw_laddr;
  assign nxt_sector    = x_done ? x_sector : cdb_w[9] ? i_upd.cdb_data : sw_sector[7:0];
  assign nxt_head      = x_done ? x_head : cdb_w[10] ? i_upd.cdb_data : sw_head[7:0];
  assign nxt_cyl_num   = x_done ? x_cyl : hw_cyl_num[15:0];
  assign nxt_phase     = i_upd.phase_we ? i_upd.phase : sw_phase[6:0];
  assign nxt_sync      = sw_sync[6:0];

  // unit register: identify image, received status, unexpected reselection
  assign nxt_lun = i_upd.unexp_we  ? {5'b00000, i_upd.unexp_lun} :
                   i_upd.ident_we  ? {i_upd.ident_valid,
                                      i_upd.ident_valid && i_upd.ident_dok,
                                      3'b000,
                                      i_upd.ident_valid ? i_upd.ident_lun : 3'b000} :
                   i_upd.status_we ? i_upd.status :
                   sw_lun[7:0];

  // command block byte view for the sending engine
  assign cdb_rd = !scdb_pkg::cdb_allowed(i_cdb_rd_idx, i_cdb_len) ? 8'h00 :
                  (i_cdb_rd_idx == 4'h3) ? cyl_total_ff[7:0] :
                  (i_cdb_rd_idx == 4'h4) ? cyl_total_ff[15:8] :
                  (i_cdb_rd_idx == 4'h5) ? laddr_ff[7:0] :
                  (i_cdb_rd_idx == 4'h6) ? laddr_ff[15:8] :
                  (i_cdb_rd_idx == 4'h7) ? laddr_ff[23:16] :
                  (i_cdb_rd_idx == 4'h8) ? laddr_ff[31:24] :
                  (i_cdb_rd_idx == 4'h9) ? sector_ff :
                  (i_cdb_rd_idx == 4'hA) ? head_ff :
                  (i_cdb_rd_idx == 4'hB) ? cyl_num_ff[7:0] : cyl_num_ff[15:8];

  // completion message choice
  assign msg = !cyl_num_ff[scdb_pkg::CMS_LINK_BIT] ? scdb_pkg::MSG_COMPLETE :
               cyl_num_ff[scdb_pkg::CMS_FLAG_BIT]  ? scdb_pkg::MSG_LINKED_FLAG :
                                                     scdb_pkg::MSG_LINKED;

  assign nxt_view.cdb_rd_data  = cdb_rd;
  assign nxt_view.ident_lun    = lun_ff[2:0];
  assign nxt_view.status_byte  = cyl_num_ff[7:0];
  assign nxt_view.complete_msg = msg;
  assign nxt_view.phase        = phase_ff;

  // read multiplexer, unused bits zero
  assign rd_mux = (i_paddr == scdb_pkg::OFS_CYL_TOTAL) ? {16'h0000, cyl_total_ff} :
                  (i_paddr == scdb_pkg::OFS_LADDR)     ? laddr_ff :
                  (i_paddr == scdb_pkg::OFS_SECTOR)    ? {24'h000000, sector_ff} :
                  (i_paddr == scdb_pkg::OFS_HEAD)      ? {24'h000000, head_ff} :
                  (i_paddr == scdb_pkg::OFS_CYL_NUM)   ? {16'h0000, cyl_num_ff} :
                  (i_paddr == scdb_pkg::OFS_LUN)       ? {24'h000000, lun_ff} :
                  (i_paddr == scdb_pkg::OFS_PHASE)     ? {25'h0000000, phase_ff} :
                  (i_paddr == scdb_pkg::OFS_SYNC)      ? {25'h0000000, sync_ff} : 32'h0000_0000;

  // APB answer registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_ff  <= scdb_pkg::RST_ZERO;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !mapped;
      if (setup) begin
        prdata_ff <= (mapped && !i_pwrite) ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // geometry and command block registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cyl_total_ff <= '0;
      laddr_ff     <= '0;
      sector_ff    <= '0;
      head_ff      <= '0;
      cyl_num_ff   <= '0;
    end else begin
      cyl_total_ff <= nxt_cyl_total;
      laddr_ff     <= nxt_laddr;
      sector_ff    <= nxt_sector;
      head_ff      <= nxt_head;
      cyl_num_ff   <= nxt_cyl_num;
    end
  end

  // unit, phase and transfer registers, engine view
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lun_ff   <= '0;
      phase_ff <= '0;
      sync_ff  <= '0;
      view_ff  <= '0;
    end else begin
      lun_ff   <= nxt_lun;
      phase_ff <= nxt_phase;
      sync_ff  <= nxt_sync;
      view_ff  <= nxt_view;
    end
  end

  // address translation engine
  scdb_xlate u_xlate (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_start    (i_xlate_start),
    .i_laddr    (laddr_ff),
    .i_spt      (i_total_sectors),
    .i_heads    (i_total_heads),
    .i_spare    (head_ff),
    .i_cyl_init (cyl_num_ff),
    .o_busy     (x_busy),
    .o_done     (x_done),
    .o_sector   (x_sector),
    .o_head     (x_head),
    .o_cyl      (x_cyl)
  );

  // transfer mode decode
  scdb_sync_decode u_sync (
    .i_clk        (i_clk),
    .i_resetn     (i_resetn),
    .i_sync       (sync_ff),
    .i_data_phase (i_data_phase),
    .o_xfer       (o_xfer)
  );

  assign o_prdata     = prdata_ff;
  assign o_pready     = pready_ff;
  assign o_pslverr    = pslverr_ff;
  assign o_view       = view_ff;
  assign o_xlate_busy = x_busy;
  assign o_xlate_done = x_done;

endmodule : scdb_regs
`default_nettype wire

// ---- tb/scdb_regs_chk.sv ----
// Purpose: port checker of the register bank
// Assumes: zero wait APB slave
// Notes:   bound to scdb_regs below
`timescale 1ns/1ps
`default_nettype none
module scdb_regs_chk (
  input wire logic        i_clk, i_resetn, i_psel, i_penable, i_pwrite, i_xlate_start,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready, o_pslverr, o_xlate_busy, o_xlate_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // read access qualifier
  wire logic rd = o_pready && !i_pwrite;
  property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing");
  property p_err; o_pready && i_paddr > 8'h1C |-> o_pslverr; endproperty
  a_err: assert property (p_err) else $error("pslverr missing");
  property p_ph; rd && i_paddr == 8'h18 |-> o_prdata[31:7] == 0; endproperty
  a_ph: assert property (p_ph) else $error("phase high bits set");
  property p_sy; rd && i_paddr == 8'h1C |-> o_prdata[31:7] == 0; endproperty
  a_sy: assert property (p_sy) else $error("sync high bits set");
  property p_cy; rd && (i_paddr == 8'h00 || i_paddr == 8'h10) |-> o_prdata[31:16] == 0; endproperty
  a_cy: assert property (p_cy) else $error("cylinder above 16 bits");
  property p_ln; rd && i_paddr == 8'h14 |-> o_prdata[31:8] == 0; endproperty
  a_ln: assert property (p_ln) else $error("unit high bits set");
  property p_dn; i_xlate_start && !o_xlate_busy |-> ##[64:67] o_xlate_done; endproperty
  a_dn: assert property (p_dn) else $error("translation done late");
  property p_bz; i_xlate_start && !o_xlate_busy |=> o_xlate_busy [*8]; endproperty
  a_bz: assert property (p_bz) else $error("busy dropped early");
  property p_one; o_xlate_done |=> !o_xlate_done; endproperty
  a_one: assert property (p_one) else $error("done longer than a cycle");
endmodule : scdb_regs_chk
bind scdb_regs scdb_regs_chk u_chk (.*);
`default_nettype wire

// ---- tb/scdb_engine.sv ----
// Purpose: command engine model that stores received block bytes
// Assumes: one byte per cycle
// Notes:   idle data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module scdb_engine (
  input  wire logic           i_clk,
  input  wire logic           i_go,
  input  wire logic [3:0]     i_idx,
  input  wire logic [7:0]     i_data,
  output scdb_pkg::scdb_upd_t o_upd
);
  // one-cycle byte store pulse per request
  always_ff @(posedge i_clk) begin
    o_upd          <= '0;
    o_upd.cdb_we   <= i_go;
    o_upd.cdb_idx  <= i_idx;
    o_upd.cdb_data <= i_go ? i_data : ~i_data;
  end
endmodule : scdb_engine
`default_nettype wire

// ---- tb/scdb_regs_test.sv ----
// Purpose: self-checking bench of the register bank
// Assumes: zero wait APB, engine model on the update port
// Notes:   expected register images kept in ex
`timescale 1ns/1ps
`default_nettype none
module scdb_regs_test;
  logic i_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_xlate_start = 0, i_data_phase = 0;
  logic go = 0, o_pready, o_pslverr, o_xlate_busy, o_xlate_done, er;
  logic [7:0]  i_paddr = 0, i_total_sectors = 8'h11, i_total_heads = 8'h05, bd = 0;
  logic [31:0] i_pwdata = 0, o_prdata, v;
  logic [3:0]  i_pstrb = 4'hF, i_cdb_rd_idx = 0;
  scdb_pkg::scdb_len_t  i_cdb_len = scdb_pkg::SCDB_LEN12;
  scdb_pkg::scdb_upd_t  i_upd;
  scdb_pkg::scdb_view_t o_view;
  scdb_pkg::scdb_xfer_t o_xfer;
  int n_errors = 0, cmp_count = 0, r, q, c;
  int unsigned ex[8], la, m[8] = '{32'hFFFF, 32'hFFFFFFFF, 32'hFF, 32'hFF, 32'hFFFF, 32'hC7, 32'h7F, 32'h7F};
  scdb_regs u_dut (.*);
  scdb_engine u_eng (.i_clk(i_clk), .i_go(go), .i_idx(i_cdb_rd_idx), .i_data(bd), .o_upd(i_upd));
  initial forever #20 i_clk = ~i_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin n_errors++; $display("Error %s exp %h got %h", nm, e, s); end
  endtask : chk
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge i_clk); i_psel <= 1; i_penable <= 0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clk); i_penable <= 1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    v = o_prdata; er = o_pslverr; i_psel <= 0; i_penable <= 0;
  endtask : bus
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (30000) @(posedge i_clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h0d193536));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1;
    // masked readback, unmapped read
    for (r = 0; r < 8; r++) begin ex[r] = $urandom & m[r]; bus(1, r * 4, ex[r] | ~m[r]); end
    for (r = 0; r < 8; r++) begin bus(0, r * 4, 0); chk("reg", ex[r], v); end
    bus(0, 8'h20, 0); chk("slverr", 1, er);
    // received block bytes per length
    for (c = 2; c >= 0; c--) begin
      i_cdb_len <= scdb_pkg::scdb_len_t'(c[1:0]);
      for (q = 3; q < 13; q++) begin
        la = $urandom;
        @(posedge i_clk); go <= 1; i_cdb_rd_idx <= q[3:0]; bd <= la[7:0];
        r = q < 5 ? 0 : q < 9 ? 1 : q == 9 ? 2 : q == 10 ? 3 : 4;
        if (q < 7 || (c > 0 && q < 11) || c == 2) ex[r][(q - (q < 5 ? 3 : q < 9 ? 5 : q > 10 ? 11 : q)) * 8 +: 8] = la[7:0];
      end
      @(posedge i_clk); go <= 0;
      repeat (2) @(posedge i_clk);
      for (r = 0; r < 5; r++) begin bus(0, r * 4, 0); chk("cdb", ex[r], v); end
    end
    // plain and compensated translation
    for (c = 0; c < 2; c++) begin
      la = $urandom % 32'h30000; q = c ? 3 : 0; r = 85 - q;
      ex[4] = c ? la / r : la / 85;
      ex[2] = c ? la % r % 17 : la % 17;
      ex[3] = c ? la % r / 17 : la / 17 % 5;
      bus(1, 8'h04, la); bus(1, 8'h0C, q); bus(1, 8'h10, r);
      @(posedge i_clk); i_xlate_start <= 1;
      @(posedge i_clk); i_xlate_start <= 0;
      for (q = 0; q < 80 && o_xlate_done !== 1'b1; q++) @(posedge i_clk);
      for (r = 2; r < 5; r++) begin bus(0, r * 4, 0); chk("xlate", ex[r], v); end
    end
    // status byte and completion message
    for (c = 0; c < 4; c++) begin
      la = $urandom; bus(1, 8'h10, {22'h0, c[1:0], la[7:0]});
      repeat (2) @(posedge i_clk);
      chk("status", la[7:0], o_view.status_byte);
      chk("msg", c[0] ? (c[1] ? 8'h0B : 8'h0A) : 8'h00, o_view.complete_msg);
    end
    // offset and period decode
    for (c = 0; c < 16; c++) begin
      la = $urandom; i_data_phase <= la[7]; bus(1, 8'h1C, {25'h0, la[6:4], c[3:0]});
      repeat (3) @(posedge i_clk);
      chk("offset", c < 13 ? c : 0, o_xfer.offset);
      chk("undef", c > 12, o_xfer.offset_undef);
      chk("sync", la[7] && c > 0 && c < 13, o_xfer.sync_en);
      chk("period", la[6:5] != 0 ? la[6:4] : 8, o_xfer.period);
    end
    wrap_up;
  end
endmodule : scdb_regs_test
`default_nettype wire
